/* File: hdl/vlan_access_pkg.sv */
// Constants for the table access block: register numbers, fields, timing.
// Assumes a 25 MHz switch core clock and word-indexed register numbers.
package vlan_access_pkg;

   // ************************************************************
   // Register numbers (indices on the register port)
   // ************************************************************
   localparam logic [15:0] LOOKUP_AGE_CONFIG_IDX         = 16'h1809;
   localparam logic [15:0] VLAN_TABLE_COMMAND_IDX        = 16'h180b;
   localparam logic [15:0] VLAN_TABLE_WRITE_DATA_IDX     = 16'h180c;
   localparam logic [15:0] VLAN_TABLE_READ_DATA_IDX      = 16'h180e;
   localparam logic [15:0] VLAN_TABLE_COMMAND_STATUS_IDX = 16'h1810;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic        AGE_CONFIG_RESET = 1'b0;
   localparam logic [5:0]  COMMAND_RESET    = 6'h00;
   localparam logic [17:0] WRITE_DATA_RESET = 18'h00000;
   localparam logic [17:0] READ_DATA_RESET  = 18'h00000;
   localparam logic [14:0] PORT_DEF_RESET   = 15'h0000;
   localparam logic [17:0] ENTRY_RESET      = 18'h00000;

   // ************************************************************
   // Field positions and widths
   // ************************************************************
   localparam int AGE_TEST_BIT    = 0;
   localparam int CMD_RNW_BIT     = 5;
   localparam int CMD_PORT_SEL    = 4;
   localparam int CMD_INDEX_MSB   = 3;
   localparam int CMD_WIDTH       = 6;
   localparam int DATA_WIDTH      = 18;
   localparam int PDEF_WIDTH      = 15;
   localparam int VID_MSB         = 11;
   localparam int PRIO_LSB        = 12;
   localparam int PRIO_MSB        = 14;
   localparam int UNTAG_P0_BIT    = 12;
   localparam int MEMBER_P0_BIT   = 13;
   localparam int PENDING_BIT     = 0;
   localparam int VLAN_ENTRIES    = 16;
   localparam int PORT_COUNT      = 3;
   localparam logic [11:0] NULL_VID = 12'h000;

   // ************************************************************
   // Aging timing
   // ************************************************************
   localparam longint unsigned CLK_HZ          = 64'd25_000_000;
   localparam longint unsigned AGE_NORMAL_MIN  = 64'd5;
   localparam longint unsigned AGE_TEST_MS     = 64'd50;
   localparam longint unsigned AGE_NORMAL_CYCLES =
      AGE_NORMAL_MIN * 64'd60 * CLK_HZ;
   localparam longint unsigned AGE_TEST_CYCLES =
      AGE_TEST_MS * CLK_HZ / 64'd1000;

endpackage

/* File: hdl/vlan_entry_ram.sv */
// Small entry store for the VLAN membership table.
// Assumes one writer/reader (the command engine) on the core clock.
`timescale 1ns/1ps
`default_nettype none

module vlan_entry_ram #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 18,
   parameter int AW    = 4
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Access port
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   input  wire logic [AW-1:0]          addr,
   input  wire logic [WIDTH-1:0]       wdata,
   output logic      [WIDTH-1:0]       rdata,
   // All entries, for the parallel lookup
   output logic      [DEPTH*WIDTH-1:0] entries
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rd;
   } ram_state_t;

   ram_state_t st_reg;
   ram_state_t st_next;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      if (wr_en) begin
         st_next.mem[addr] = wdata;
      end
      // Registered read keeps the lookup path free of this mux
      if (rd_en) begin
         st_next.rd = st_reg.mem[addr];
      end
   end

   // Entries clear at reset so no stale VLAN matches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata   = st_reg.rd;
   assign entries = st_reg.mem;

endmodule

`default_nettype wire

/* File: hdl/vlan_table_access.sv */
// Register access port for the VLAN and per-port default VID tables,
// aging tick generator and ingress VLAN classification.
// Assumes register strobes and packet inputs come from MCLK logic.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Age-test bit shortens the aging tick period from five minutes to 50 ms.
// - Any write to the command register starts the table access at once.
// - Command bit 5 high reads the selected entry, low writes it.
// - Command bit 4 high picks the port default table, low the VLAN table.
// - Read data is valid once the pending flag has dropped.
// - Port entry holds default VID in 11:0 and priority in 14:12.
// - Untagged or null-VID packets take the port default VID and priority.
// - Port default VID and priority are zero after reset.
// - Entry bit 17 makes port 2 a member for ingress and egress.
// - Non-member ingress is dropped unless admit-outsider is set.
// - Entry bit 16 strips the tag of port 2 traffic on hybrid egress.
// - Entry bit 15 is port 1 membership, same as port 2.
// - Bits 14, 13, 12 are port 1 untag, port 0 member, port 0 untag.
// - Entry bits 11:0 hold the VID; zero disables the entry.
// - A finished read places the entry in the read data register.
module vlan_table_access
   import vlan_access_pkg::*;
#(
   parameter longint unsigned AGE_NORMAL_LEN = AGE_NORMAL_CYCLES,
   parameter longint unsigned AGE_TEST_LEN   = AGE_TEST_CYCLES
) (
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   // Register port
   input  wire logic [15:0] REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [31:0] REG_WDATA,
   output logic      [31:0] REG_RDATA,
   output logic             REG_RVALID,
   // Status
   output logic             OP_PENDING,
   output logic             AGE_TICK,
   // Packet classification request
   input  wire logic        PKT_VALID,
   input  wire logic [1:0]  PKT_PORT,
   input  wire logic        PKT_TAGGED,
   input  wire logic [11:0] PKT_VID,
   input  wire logic [2:0]  PKT_PRIO,
   input  wire logic [2:0]  ADMIT_OUTSIDER,
   // Classification answer
   output logic             CLS_VALID,
   output logic      [11:0] CLS_VID,
   output logic      [2:0]  CLS_PRIO,
   output logic             CLS_ADMIT,
   output logic             CLS_STRIP,
   output logic      [2:0]  CLS_MEMBERS
);
   import vlan_access_pkg::*;

   localparam int AGE_W = $clog2(AGE_NORMAL_LEN + 64'd1);

   typedef enum logic [1:0] {IDLE, EXEC, FINISH} engine_t;

   typedef struct packed {
      logic                            age_test;
      logic [CMD_WIDTH-1:0]            cmd;
      logic [DATA_WIDTH-1:0]           wdata;
      logic [DATA_WIDTH-1:0]           rdata;
      logic                            pending;
      engine_t                         eng;
      logic [PORT_COUNT-1:0][PDEF_WIDTH-1:0] pdef;
      logic [AGE_W-1:0]                age_cnt;
      logic                            age_tick;
      logic [31:0]                     bus_rdata;
      logic                            bus_rvalid;
      logic                            cls_valid;
      logic [11:0]                     cls_vid;
      logic [2:0]                      cls_prio;
      logic                            cls_admit;
      logic                            cls_strip;
      logic [2:0]                      cls_members;
   } state_t;

   state_t st_reg;
   state_t st_next;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic reg_hit(input logic [15:0] a,
                                    input logic [15:0] idx);
      reg_hit = (a == idx);
   endfunction

   function automatic logic member_of(input logic [17:0] e,
                                      input logic [1:0]  p);
      member_of = e[MEMBER_P0_BIT + 2 * int'(p)];
   endfunction

   function automatic logic untag_of(input logic [17:0] e,
                                     input logic [1:0]  p);
      untag_of = e[UNTAG_P0_BIT + 2 * int'(p)];
   endfunction

   // ************************************************************
   // Entry store
   // ************************************************************
   logic                               ram_wr;
   logic                               ram_rd;
   logic [DATA_WIDTH-1:0]              ram_rdata;
   logic [VLAN_ENTRIES*DATA_WIDTH-1:0] ram_entries;
   logic                               cmd_wr;
   logic                               port_ok;

   assign cmd_wr  = REG_WR && reg_hit(REG_ADDR, VLAN_TABLE_COMMAND_IDX);
   assign port_ok = st_reg.cmd[CMD_INDEX_MSB:0] < 4'(PORT_COUNT);
   // VLAN table touched only in EXEC, selected by bit 4 clear
   assign ram_wr = (st_reg.eng == EXEC) && !st_reg.cmd[CMD_PORT_SEL]
                   && !st_reg.cmd[CMD_RNW_BIT];
   assign ram_rd = (st_reg.eng == EXEC) && !st_reg.cmd[CMD_PORT_SEL]
                   && st_reg.cmd[CMD_RNW_BIT];

   vlan_entry_ram #(
      .DEPTH (VLAN_ENTRIES),
      .WIDTH (DATA_WIDTH),
      .AW    (4)
   ) u_ram (
      .clk     (MCLK),
      .rst_n   (RSTN),
      .wr_en   (ram_wr),
      .rd_en   (ram_rd),
      .addr    (st_reg.cmd[CMD_INDEX_MSB:0]),
      .wdata   (st_reg.wdata),
      .rdata   (ram_rdata),
      .entries (ram_entries)
   );

   // ************************************************************
   // Lookup of the incoming packet
   // ************************************************************
   logic [11:0] eff_vid;
   logic [2:0]  eff_prio;
   logic        hit;
   logic [17:0] hit_entry;
   logic [14:0] port_def;

   always_comb begin
      port_def = (PKT_PORT < 2'(PORT_COUNT)) ? st_reg.pdef[PKT_PORT]
                                             : PORT_DEF_RESET;
      // Untagged or null tag falls back to the port defaults
      if (!PKT_TAGGED || PKT_VID == NULL_VID) begin
         eff_vid  = port_def[VID_MSB:0];
         eff_prio = port_def[PRIO_MSB:PRIO_LSB];
      end else begin
         eff_vid  = PKT_VID;
         eff_prio = PKT_PRIO;
      end
      hit       = 1'b0;
      hit_entry = ENTRY_RESET;
      // Lowest index wins; a zero VID entry never matches
      for (int i = VLAN_ENTRIES - 1; i >= 0; i--) begin
         if (ram_entries[i*DATA_WIDTH +: 12] == eff_vid
             && eff_vid != NULL_VID) begin
            hit       = 1'b1;
            hit_entry = ram_entries[i*DATA_WIDTH +: DATA_WIDTH];
         end
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   logic [AGE_W-1:0] age_limit;

   always_comb begin
      st_next   = st_reg;
      age_limit = st_reg.age_test ? AGE_W'(AGE_TEST_LEN - 64'd1)
                                  : AGE_W'(AGE_NORMAL_LEN - 64'd1);

      // Register writes; reserved bits are simply not stored
      if (REG_WR && reg_hit(REG_ADDR, LOOKUP_AGE_CONFIG_IDX)) begin
         st_next.age_test = REG_WDATA[AGE_TEST_BIT];
      end
      if (REG_WR && reg_hit(REG_ADDR, VLAN_TABLE_WRITE_DATA_IDX)) begin
         st_next.wdata = REG_WDATA[DATA_WIDTH-1:0];
      end

      // Command engine
      case (st_reg.eng)
         IDLE: begin
         end
         EXEC: begin
            if (st_reg.cmd[CMD_PORT_SEL] && !st_reg.cmd[CMD_RNW_BIT]
                && port_ok) begin
               st_next.pdef[st_reg.cmd[1:0]] =
                  st_reg.wdata[PDEF_WIDTH-1:0];
            end
            st_next.eng = FINISH;
         end
         FINISH: begin
            if (st_reg.cmd[CMD_RNW_BIT]) begin
               if (st_reg.cmd[CMD_PORT_SEL]) begin
                  st_next.rdata = port_ok ?
                     {3'h0, st_reg.pdef[st_reg.cmd[1:0]]} : READ_DATA_RESET;
               end else begin
                  st_next.rdata = ram_rdata;
               end
            end
            st_next.pending = 1'b0;
            st_next.eng     = IDLE;
         end
         default: begin
            st_next.eng = IDLE;
         end
      endcase

      // A new command restarts the engine even mid access
      if (cmd_wr) begin
         st_next.cmd     = REG_WDATA[CMD_WIDTH-1:0];
         st_next.pending = 1'b1;
         st_next.eng     = EXEC;
      end

      // Aging tick; >= catches a shortened limit mid count
      st_next.age_tick = 1'b0;
      if (st_reg.age_cnt >= age_limit) begin
         st_next.age_cnt  = '0;
         st_next.age_tick = 1'b1;
      end else begin
         st_next.age_cnt = st_reg.age_cnt + AGE_W'(1);
      end

      // Register reads answer one cycle later
      st_next.bus_rvalid = REG_RD;
      st_next.bus_rdata  = 32'h00000000;
      if (REG_RD) begin
         if (reg_hit(REG_ADDR, LOOKUP_AGE_CONFIG_IDX)) begin
            st_next.bus_rdata = {31'h0, st_reg.age_test};
         end else if (reg_hit(REG_ADDR, VLAN_TABLE_COMMAND_IDX)) begin
            st_next.bus_rdata = {26'h0, st_reg.cmd};
         end else if (reg_hit(REG_ADDR, VLAN_TABLE_WRITE_DATA_IDX)) begin
            st_next.bus_rdata = {14'h0, st_reg.wdata};
         end else if (reg_hit(REG_ADDR, VLAN_TABLE_READ_DATA_IDX)) begin
            st_next.bus_rdata = {14'h0, st_reg.rdata};
         end else if (reg_hit(REG_ADDR,
                              VLAN_TABLE_COMMAND_STATUS_IDX)) begin
            st_next.bus_rdata = {31'h0, st_reg.pending};
         end
      end

      // Classification answer
      st_next.cls_valid   = PKT_VALID;
      st_next.cls_vid     = eff_vid;
      st_next.cls_prio    = eff_prio;
      st_next.cls_members = hit ? {hit_entry[17], hit_entry[15],
                                   hit_entry[13]} : 3'h0;
      st_next.cls_admit   = (hit && member_of(hit_entry, PKT_PORT))
                            || ADMIT_OUTSIDER[PKT_PORT];
      st_next.cls_strip   = hit && untag_of(hit_entry, PKT_PORT);
   end

   // Single state register; reset clears both tables too
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         st_reg          <= '0;
         st_reg.eng      <= IDLE;
         st_reg.age_test <= AGE_CONFIG_RESET;
         st_reg.cmd      <= COMMAND_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign REG_RDATA   = st_reg.bus_rdata;
   assign REG_RVALID  = st_reg.bus_rvalid;
   assign OP_PENDING  = st_reg.pending;
   assign AGE_TICK    = st_reg.age_tick;
   assign CLS_VALID   = st_reg.cls_valid;
   assign CLS_VID     = st_reg.cls_vid;
   assign CLS_PRIO    = st_reg.cls_prio;
   assign CLS_ADMIT   = st_reg.cls_admit;
   assign CLS_STRIP   = st_reg.cls_strip;
   assign CLS_MEMBERS = st_reg.cls_members;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   a_cmd_sets_pending: assert property (
      cmd_wr |=> OP_PENDING)
      else $error("pending not set after command write");

   a_pending_drops: assert property (
      (cmd_wr ##1 !cmd_wr [*2]) |=> !OP_PENDING)
      else $error("pending not cleared two cycles after command");

   a_rdata_stable: assert property (
      $changed(st_reg.rdata) |-> $past(st_reg.eng) == FINISH)
      else $error("read data changed outside completion");

   a_age_short: assert property (
      (st_reg.age_test && $past(st_reg.age_test)) |->
         st_reg.age_cnt < AGE_W'(AGE_TEST_LEN))
      else $error("age counter exceeds test interval");

   a_age_wrap: assert property (
      AGE_TICK |-> st_reg.age_cnt == '0 && $past(st_reg.age_cnt) != '0)
      else $error("age tick without counter wrap");

   a_reset_defaults: assert property (
      $past(!RSTN) |-> st_reg.pdef == '0)
      else $error("port defaults not zero after reset");

   a_reserved_zero: assert property (
      (REG_RD && reg_hit(REG_ADDR, LOOKUP_AGE_CONFIG_IDX)) |=>
         REG_RVALID && REG_RDATA[31:1] == 31'h0)
      else $error("reserved age config bits not zero");

   a_untag_default: assert property (
      (PKT_VALID && !PKT_TAGGED && PKT_PORT < 2'(PORT_COUNT)) |=>
         CLS_VID == $past(port_def[VID_MSB:0]) && CLS_VALID)
      else $error("untagged packet did not take default VID");

   a_member_admit: assert property (
      (PKT_VALID && PKT_PORT == 2'd2 && !ADMIT_OUTSIDER[2]) |=>
         CLS_ADMIT == $past(hit && hit_entry[17]))
      else $error("port 2 admission does not follow member bit");

   c_table_read:  cover property (cmd_wr && REG_WDATA[CMD_RNW_BIT]
                                  ##3 !OP_PENDING);
   c_port_write:  cover property (cmd_wr && REG_WDATA[CMD_PORT_SEL]
                                  && !REG_WDATA[CMD_RNW_BIT]);
   c_admit_drop:  cover property (CLS_VALID && !CLS_ADMIT);
   c_strip:       cover property (CLS_VALID && CLS_STRIP);

endmodule

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the VLAN table access block.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import vlan_access_pkg::*;

   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic        mclk, rstn, reg_wr, reg_rd, reg_rvalid, op_pending;
   logic        age_tick, pkt_valid, pkt_tagged, cls_valid, cls_admit;
   logic        cls_strip;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [1:0]  pkt_port;
   logic [11:0] pkt_vid, cls_vid;
   logic [2:0]  pkt_prio, admit_outsider, cls_prio, cls_members;
   int          n_fail, cmp_count;
   logic [15:0] regs [6] = '{16'h1809, 16'h180a, 16'h180b, 16'h180c,
                             16'h180e, 16'h1810};
   logic [3:0]  vidx [3] = '{4'h0, 4'h1, 4'hf};
   logic [17:0] vent [3] = '{18'h3f000, 18'h36101, 18'h0c0a5};

   // Short aging lengths keep the run brief
   vlan_table_access #(.AGE_NORMAL_LEN(64'd40), .AGE_TEST_LEN(64'd8)) dut (
      .MCLK(mclk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .OP_PENDING(op_pending),
      .AGE_TICK(age_tick), .PKT_VALID(pkt_valid), .PKT_PORT(pkt_port),
      .PKT_TAGGED(pkt_tagged), .PKT_VID(pkt_vid), .PKT_PRIO(pkt_prio),
      .ADMIT_OUTSIDER(admit_outsider), .CLS_VALID(cls_valid),
      .CLS_VID(cls_vid), .CLS_PRIO(cls_prio), .CLS_ADMIT(cls_admit),
      .CLS_STRIP(cls_strip), .CLS_MEMBERS(cls_members));

   vlan_host_model host (
      .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   // 25 MHz core clock
   initial mclk = 1'b0;
   always #20 mclk = ~mclk;

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One packet; answer expected exactly one cycle later
   task automatic pkt(input logic [1:0] p, input logic tg,
                      input logic [11:0] v, input logic [19:0] exp);
      @(posedge mclk) #1;
      pkt_valid  = 1'b1;
      pkt_port   = p;
      pkt_tagged = tg;
      pkt_vid    = v;
      @(posedge mclk) #1;
      pkt_valid  = 1'b0;
      pkt_vid    = ~v;
      check({11'h0, cls_valid, cls_vid, cls_prio, cls_admit, cls_strip,
             cls_members}, {12'h001, exp}, "classify");
   endtask

   // Gap between two aging ticks, bounded
   task automatic age_gap(input int exp);
      int n;
      n = 0;
      while (age_tick !== 1'b1 && n < 100) begin
         @(posedge mclk) #1;
         n++;
      end
      n = 0;
      do begin
         @(posedge mclk) #1;
         n++;
      end while (age_tick !== 1'b1 && n < 100);
      check(32'(n), 32'(exp), "tick gap");
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      rstn = 1'b0;
      pkt_valid = 1'b0;
      pkt_port = 2'd0;
      pkt_tagged = 1'b0;
      pkt_vid = 12'h000;
      pkt_prio = 3'h3;
      admit_outsider = 3'b000;
      n_fail = 0;
      cmp_count = 0;
      repeat (16) @(posedge mclk);
      #1 rstn = 1'b1;
      // Reset values, one unmapped place among them
      foreach (regs[i]) begin
         host.rd(regs[i], d);
         check(d, 32'h0, "reset reg");
      end
      for (int p = 0; p < 3; p++) begin
         host.tbl_rd(1'b1, 4'(p), d);
         check(d, 32'h0, "port default reset");
      end
      // Reserved bits read zero, read data ignores writes
      host.wr(LOOKUP_AGE_CONFIG_IDX, 32'hffffffff);
      host.rd(LOOKUP_AGE_CONFIG_IDX, d);
      check(d, 32'h1, "age cfg");
      host.wr(VLAN_TABLE_READ_DATA_IDX, 32'hffffffff);
      host.rd(VLAN_TABLE_READ_DATA_IDX, d);
      check(d, 32'h0, "read data ro");
      host.wr(VLAN_TABLE_WRITE_DATA_IDX, 32'hffffffff);
      host.rd(VLAN_TABLE_WRITE_DATA_IDX, d);
      check(d, 32'h3ffff, "wdata");
      host.wr(VLAN_TABLE_COMMAND_IDX, 32'hffffffd2);
      host.wait_done();
      host.rd(VLAN_TABLE_COMMAND_IDX, d);
      check(d, 32'h12, "cmd");
      host.tbl_rd(1'b1, 4'd2, d);
      check(d, 32'h7fff, "port fields");
      // Port defaults: VID 0 and all-ones avoided
      for (int p = 0; p < 3; p++) begin
         host.tbl_wr(1'b1, 4'(p), {17'h0, 3'(p + 4), 12'(12'h101 + p)});
         host.tbl_rd(1'b1, 4'(p), d);
         check(d, {17'h0, 3'(p + 4), 12'(12'h101 + p)}, "port");
      end
      // Membership entries, first and last index included
      foreach (vidx[i]) begin
         host.tbl_wr(1'b0, vidx[i], {14'h0, vent[i]});
      end
      foreach (vidx[i]) begin
         host.tbl_rd(1'b0, vidx[i], d);
         check(d, {14'h0, vent[i]}, "entry");
      end
      // Pending high for exactly two cycles after a command write
      host.wr(VLAN_TABLE_COMMAND_IDX, 32'h00000021);
      check({31'h0, op_pending}, 32'h1, "pending 1");
      @(posedge mclk) #1;
      check({31'h0, op_pending}, 32'h1, "pending 2");
      @(posedge mclk) #1;
      check({31'h0, op_pending}, 32'h0, "pending 3");
      host.rd(VLAN_TABLE_READ_DATA_IDX, d);
      check(d, 32'h36101, "read after pending");
      // Classification through the programmed tables
      pkt(2'd2, 1'b1, 12'h101, {12'h101, 3'h3, 5'b11101});
      pkt(2'd1, 1'b1, 12'h101, {12'h101, 3'h3, 5'b01101});
      admit_outsider = 3'b010;
      pkt(2'd1, 1'b1, 12'h101, {12'h101, 3'h3, 5'b11101});
      admit_outsider = 3'b000;
      pkt(2'd0, 1'b0, 12'h0a5, {12'h101, 3'h4, 5'b10101});
      pkt(2'd1, 1'b1, 12'h0a5, {12'h0a5, 3'h3, 5'b11010});
      pkt(2'd2, 1'b1, 12'h0a5, {12'h0a5, 3'h3, 5'b00010});
      pkt(2'd1, 1'b1, 12'h000, {12'h102, 3'h5, 5'b00000});
      // Aging interval, normal then shortened
      host.wr(LOOKUP_AGE_CONFIG_IDX, 32'h0);
      age_gap(40);
      host.wr(LOOKUP_AGE_CONFIG_IDX, 32'h1);
      age_gap(8);
      stop_test();
   end
endmodule

`default_nettype wire

/* File: verification/vlan_host_model.sv */
// Host software model driving the register port of the table access block.
// Assumes the bench top is testbench and owns n_fail and stop_test.
`timescale 1ns/1ps
`default_nettype none

module vlan_host_model (
   // Clock
   input  wire logic        mclk,
   // Register port
   output logic      [15:0] reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [31:0] reg_wdata,
   input  wire logic [31:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   import vlan_access_pkg::*;

   // ************************************************************
   // Register cycles
   // ************************************************************
   initial begin
      reg_addr  = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 32'h00000000;
   end

   // Address and data scrambled after release so stale values never help
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk) #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge mclk) #1;
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask

   // Answer has a fixed one-cycle latency
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge mclk) #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge mclk) #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rvalid ? reg_rdata : 32'hxxxxxxxx;
   endtask

   // Bounded poll of the pending bit
   task automatic wait_done();
      logic [31:0] s;
      int          n;
      n = 0;
      do begin
         rd(VLAN_TABLE_COMMAND_STATUS_IDX, s);
         n++;
      end while (s[PENDING_BIT] !== 1'b0 && n < 16);
      if (s[PENDING_BIT] !== 1'b0) begin
         testbench.n_fail++;
         $display("MISMATCH %0t pending stuck", $time);
         testbench.stop_test();
      end
   endtask

   // Table write: data first, then command, then poll
   task automatic tbl_wr(input logic sel, input logic [3:0] idx,
                         input logic [31:0] d);
      wr(VLAN_TABLE_WRITE_DATA_IDX, d);
      wr(VLAN_TABLE_COMMAND_IDX, {26'h0, 1'b0, sel, idx});
      wait_done();
   endtask

   // Table read: command, poll, then fetch the read data word
   task automatic tbl_rd(input logic sel, input logic [3:0] idx,
                         output logic [31:0] d);
      wr(VLAN_TABLE_COMMAND_IDX, {26'h0, 1'b1, sel, idx});
      wait_done();
      rd(VLAN_TABLE_READ_DATA_IDX, d);
   endtask
endmodule

`default_nettype wire
